/* core/gpc_defines.svh */
// Constants for the gate pump configuration command registers
`ifndef GPC_DEFINES_SVH
`define GPC_DEFINES_SVH
// ==========================================
// Command codes and unlock key
`define GPC_CMD_HGP 8'h9C
`define GPC_CMD_HCL 8'h9D
`define GPC_CMD_LGP 8'h9E
`define GPC_CMD_BYP 8'h9F
`define GPC_CMD_GOA 8'hA0
`define GPC_CMD_UNLOCK 8'hFF
`define GPC_UNLOCK_KEY 8'hA5
`define GPC_LAST_PIDX 2'h2
`define GPC_PIDX_SAT 2'h3
// ==========================================
// Reset values
`define GPC_RST_HGP 8'hA0
`define GPC_RST_HCL 8'h03
`define GPC_RST_LGP 8'h00
`define GPC_RST_BYP 24'h04_0000
`define GPC_RST_GOA 24'h00_2428
`define GPC_RST_UNLOCK 8'h00
// ==========================================
// Field positions
`define GPC_HGP_CLAMP 7
`define GPC_HGP_RATIO 5:4
`define GPC_SET_LVL 2:0
`define GPC_LGP_RATIO 7
`define GPC_LGP_CLAMP 6
`define GPC_BYP_MASTER 0
`define GPC_BYP_SRC_NEG 23
`define GPC_BYP_SRC_POS 16
`define GPC_GOA_MAP 1:0
`define GPC_GOA_SLPIN 4:2
`define GPC_GOA_LEVEL 9:8
`define GPC_GOA_GCL 12:10
`define GPC_GOA_VDS 15:13
`define GPC_GOA_HIZ_NUM 19:16
`define GPC_GOA_HIZ_EN 20
// ==========================================
// Decode constants (levels in 0.1 V)
`define GPC_HGP_BASE 4'h5
`define GPC_LGP_BASE 4'h5
`define GPC_VGH_BASE_DV 8'h78
`define GPC_VGL_BASE_DV 8'h5A
`define GPC_STEP_DV 8'h05
`define GPC_LEVEL_HIZ 2'h3
`define GPC_BITS_PER_BYTE 3'h7
`endif

/* core/gpc_pkg.sv */
// Types shared by the gate pump configuration block
package gpc_pkg;
    typedef enum logic [0:0] {GPC_RUN, GPC_HIZ_HOLD} gpc_phase_e;

    typedef struct packed {
        logic [7:0] shift;
        logic [2:0] cnt;
        logic scl_prev;
        logic vld;
        logic is_cmd;
        logic [7:0] data;
    } gpc_rx_s;

    typedef struct packed {
        logic [15:0] off;
        logic all_off;
    } gpc_gate_s;

    typedef struct packed {
        gpc_phase_e phase;
        logic [7:0] cmd;
        logic [1:0] pidx;
        logic [7:0] unlock;
        logic [7:0] hgp;
        logic [7:0] hcl;
        logic [7:0] lgp;
        logic [23:0] byp;
        logic [23:0] goa;
        logic [3:0] hiz_cnt;
        logic gate_hiz;
        logic extra_go;
        logic [3:0] vgh_ratio;
        logic vgh_clamp_en;
        logic [7:0] vgh_level_dv;
        logic [3:0] vgl_ratio;
        logic vgl_clamp_en;
        logic [7:0] vgl_level_dv;
        logic pad_force;
        logic [2:0] pad_goa_sel;
        logic [2:0] pad_vds_sel;
        logic [2:0] pad_gch_sel;
        logic all_on;
        logic [1:0] all_on_level;
        logic [1:0] map_sel;
    } gpc_main_s;
endpackage

/* core/gpc_serial_rx.sv */
// Serial command byte receiver, sampled on rising shift clock
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defines.svh"
module gpc_serial_rx import gpc_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Serial pins
    input wire logic csx_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic dcx,
    // Received byte
    output gpc_rx_s rx
);
    gpc_rx_s s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.vld = 1'b0;
        s_d.scl_prev = scl;
        if (csx_n) begin
            s_d.cnt = '0;
        end else if (scl && !s_q.scl_prev) begin
            s_d.shift = {s_q.shift[6:0], sda};
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == `GPC_BITS_PER_BYTE) begin
                s_d.vld = 1'b1;
                s_d.data = {s_q.shift[6:0], sda};
                s_d.is_cmd = !dcx;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rx = s_q;

    a_byte_pulse_one: assert property (@(posedge clock) disable iff (!nrst)
        s_q.vld |=> !s_q.vld) else $error("byte strobe longer than one cycle");
endmodule // gpc_serial_rx
`default_nettype wire

/* core/gpc_supply_gate.sv */
// Test-mode supply shut-off per internal supply
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defines.svh"
module gpc_supply_gate import gpc_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Controls
    input wire logic test_mode,
    input wire logic master_off,
    input wire logic [15:0] bypass,
    // Shut-off levels
    output gpc_gate_s gate
);
    gpc_gate_s s_q, s_d;
    logic [15:0] off_w;

    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_sup
            assign off_w[i] = test_mode & (master_off | bypass[i]);
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        s_d.off = off_w;
        s_d.all_off = test_mode & master_off;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign gate = s_q;

    a_master_all_off: assert property (@(posedge clock) disable iff (!nrst)
        (test_mode && master_off) |=> (&s_q.off)) else $error("master off left a supply on");
endmodule // gpc_supply_gate
`default_nettype wire

/* core/gpc_top.sv */
// Gate pump and gate-on-array configuration command registers
// What this block does
// - High gate clamp enable bit D7: 0 disables clamp, 1 enables.
// - High gate pump ratio code 00..11 selects five to eight times supply.
// - High gate clamp level code 000..111 maps 12.0 V to 15.5 V.
// - Low gate pump ratio bit selects minus five or minus six times.
// - Low gate clamp enable bit: 0 disables clamp, 1 enables.
// - Low gate clamp level code maps -9.0 V down to -12.5 V.
// - In test mode the master off bit turns every supply off.
// - In test mode each bypass bit except bit 6 turns its supply off; reset 00h.
// - In test mode the source positive and negative bypass bits turn those supplies off.
// - In sleep-in a field picks clock, start-pulse and low-gate pad level.
// - In sleep-in a field picks the scan-direction pads level.
// - In sleep-in a field picks the charge-high pad level.
// - All-gate-on level: high rail, low rail, ground or high impedance.
// - Float-on-detect holds gates floating, then scans two extra frames.
// - Four-bit field sets the floating time before extra frames.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defines.svh"
module gpc_top import gpc_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Serial command pins
    input wire logic csx_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic dcx,
    // Device state
    input wire logic test_mode,
    input wire logic sleep_in,
    input wire logic all_gate_on,
    input wire logic low_voltage_detect,
    input wire logic two_frame_strategy,
    input wire logic line_tick,
    // Pump settings
    output logic [3:0] vgh_ratio,
    output logic vgh_clamp_en,
    output logic [7:0] vgh_level_dv,
    output logic [3:0] vgl_ratio,
    output logic vgl_clamp_en,
    output logic [7:0] vgl_level_dv,
    // Supply shut-off
    output logic [15:0] supply_off,
    output logic supply_all_off,
    // Gate pads
    output logic pad_force,
    output logic [2:0] pad_goa_sel,
    output logic [2:0] pad_vds_sel,
    output logic [2:0] pad_gch_sel,
    output logic gate_all_on,
    output logic [1:0] gate_all_on_level,
    output logic gate_hiz,
    output logic extra_frames_go,
    output logic [1:0] map_sel
);
    // ==========================================
    // Byte receiver and supply gating
    gpc_rx_s rx;
    gpc_gate_s gate;
    gpc_main_s s_q, s_d;
    logic [15:0] bypass_w;

    gpc_serial_rx u_rx (
        .clock(clock),
        .nrst(nrst),
        .csx_n(csx_n),
        .scl(scl),
        .sda(sda),
        .dcx(dcx),
        .rx(rx)
    );

    assign bypass_w = {s_q.byp[`GPC_BYP_SRC_NEG], s_q.byp[`GPC_BYP_SRC_POS],
        s_q.byp[15:8], s_q.byp[7], s_q.byp[5:1]};

    gpc_supply_gate u_gate (
        .clock(clock),
        .nrst(nrst),
        .test_mode(test_mode),
        .master_off(s_q.byp[`GPC_BYP_MASTER]),
        .bypass(bypass_w),
        .gate(gate)
    );

    // ==========================================
    // Command decode and state
    logic wr_ok;
    logic [4:0] lane;

    always_comb begin
        s_d = s_q;
        s_d.extra_go = 1'b0;
        wr_ok = (s_q.cmd == `GPC_CMD_UNLOCK) || (s_q.unlock == `GPC_UNLOCK_KEY);
        lane = {s_q.pidx, 3'b000};
        if (rx.vld) begin
            if (rx.is_cmd) begin
                s_d.cmd = rx.data;
                s_d.pidx = '0;
            end else begin
                if (wr_ok && s_q.pidx == '0) begin
                    case (s_q.cmd)
                        `GPC_CMD_UNLOCK: s_d.unlock = rx.data;
                        `GPC_CMD_HGP: s_d.hgp = rx.data;
                        `GPC_CMD_HCL: s_d.hcl = rx.data;
                        `GPC_CMD_LGP: s_d.lgp = rx.data;
                        default: ;
                    endcase
                end
                if (wr_ok && s_q.pidx <= `GPC_LAST_PIDX) begin
                    case (s_q.cmd)
                        `GPC_CMD_BYP: s_d.byp[lane +: 8] = rx.data;
                        `GPC_CMD_GOA: s_d.goa[lane +: 8] = rx.data;
                        default: ;
                    endcase
                end
                if (s_q.pidx != `GPC_PIDX_SAT) begin
                    s_d.pidx = s_q.pidx + 2'h1;
                end
            end
        end

        case (s_q.phase)
            GPC_RUN: begin
                if (low_voltage_detect && two_frame_strategy) begin
                    if (s_q.goa[`GPC_GOA_HIZ_EN]) begin
                        s_d.phase = GPC_HIZ_HOLD;
                        s_d.hiz_cnt = s_q.goa[`GPC_GOA_HIZ_NUM];
                    end else begin
                        s_d.extra_go = 1'b1;
                    end
                end
            end
            GPC_HIZ_HOLD: begin
                if (line_tick) begin
                    if (s_q.hiz_cnt == '0) begin
                        s_d.phase = GPC_RUN;
                        s_d.extra_go = 1'b1;
                    end else begin
                        s_d.hiz_cnt = s_q.hiz_cnt - 4'h1;
                    end
                end
            end
            default: s_d.phase = GPC_RUN;
        endcase

        s_d.vgh_clamp_en = s_q.hgp[`GPC_HGP_CLAMP];
        s_d.vgh_ratio = `GPC_HGP_BASE + {2'b00, s_q.hgp[`GPC_HGP_RATIO]};
        s_d.vgh_level_dv = `GPC_VGH_BASE_DV
            + 8'(`GPC_STEP_DV * {5'b0, s_q.hcl[`GPC_SET_LVL]});
        s_d.vgl_ratio = `GPC_LGP_BASE + {3'b000, s_q.lgp[`GPC_LGP_RATIO]};
        s_d.vgl_clamp_en = s_q.lgp[`GPC_LGP_CLAMP];
        s_d.vgl_level_dv = `GPC_VGL_BASE_DV
            + 8'(`GPC_STEP_DV * {5'b0, s_q.lgp[`GPC_SET_LVL]});

        s_d.pad_force = sleep_in;
        s_d.pad_goa_sel = s_q.goa[`GPC_GOA_SLPIN];
        s_d.pad_vds_sel = s_q.goa[`GPC_GOA_VDS];
        s_d.pad_gch_sel = s_q.goa[`GPC_GOA_GCL];
        s_d.all_on = all_gate_on;
        s_d.all_on_level = s_q.goa[`GPC_GOA_LEVEL];
        s_d.gate_hiz = (s_d.phase == GPC_HIZ_HOLD)
            || (all_gate_on && s_q.goa[`GPC_GOA_LEVEL] == `GPC_LEVEL_HIZ);
        s_d.map_sel = s_q.goa[`GPC_GOA_MAP];
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.phase <= GPC_RUN;
            s_q.unlock <= `GPC_RST_UNLOCK;
            s_q.hgp <= `GPC_RST_HGP;
            s_q.hcl <= `GPC_RST_HCL;
            s_q.lgp <= `GPC_RST_LGP;
            s_q.byp <= `GPC_RST_BYP;
            s_q.goa <= `GPC_RST_GOA;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Outputs
    assign vgh_ratio = s_q.vgh_ratio;
    assign vgh_clamp_en = s_q.vgh_clamp_en;
    assign vgh_level_dv = s_q.vgh_level_dv;
    assign vgl_ratio = s_q.vgl_ratio;
    assign vgl_clamp_en = s_q.vgl_clamp_en;
    assign vgl_level_dv = s_q.vgl_level_dv;
    assign supply_off = gate.off;
    assign supply_all_off = gate.all_off;
    assign pad_force = s_q.pad_force;
    assign pad_goa_sel = s_q.pad_goa_sel;
    assign pad_vds_sel = s_q.pad_vds_sel;
    assign pad_gch_sel = s_q.pad_gch_sel;
    assign gate_all_on = s_q.all_on;
    assign gate_all_on_level = s_q.all_on_level;
    assign gate_hiz = s_q.gate_hiz;
    assign extra_frames_go = s_q.extra_go;
    assign map_sel = s_q.map_sel;

    // ==========================================
    // Checks
    a_locked_no_write: assert property (@(posedge clock) disable iff (!nrst)
        (rx.vld && !rx.is_cmd && s_q.cmd == `GPC_CMD_HGP
            && s_q.unlock != `GPC_UNLOCK_KEY) |=> $stable(s_q.hgp))
        else $error("locked write changed pump setup");
    a_high_ratio: assert property (@(posedge clock) disable iff (!nrst)
        ##1 $stable(s_q.hgp) |=> vgh_ratio == 4'(5 + $past(s_q.hgp[5:4])))
        else $error("high pump ratio decode wrong");
    a_high_level: assert property (@(posedge clock) disable iff (!nrst)
        $stable(s_q.hcl) |=> vgh_level_dv == 8'(120 + 5 * $past(s_q.hcl[2:0])))
        else $error("high clamp level decode wrong");
    a_low_level: assert property (@(posedge clock) disable iff (!nrst)
        $stable(s_q.lgp) |=> vgl_level_dv == 8'(90 + 5 * $past(s_q.lgp[2:0])))
        else $error("low clamp level decode wrong");
    a_low_clamp_ratio: assert property (@(posedge clock) disable iff (!nrst)
        $stable(s_q.lgp) |=> (vgl_ratio == ($past(s_q.lgp[7]) ? 4'h6 : 4'h5))
            && (vgl_clamp_en == $past(s_q.lgp[6])))
        else $error("low pump ratio or clamp wrong");
    a_hiz_before_go: assert property (@(posedge clock) disable iff (!nrst)
        (s_q.phase == GPC_RUN && low_voltage_detect && two_frame_strategy
            && s_q.goa[20] && s_q.goa[19:16] == 4'h0) ##1 line_tick
            |=> extra_frames_go && !gate_hiz)
        else $error("extra frames not started after float");
    a_hiz_held: assert property (@(posedge clock) disable iff (!nrst)
        (s_q.phase == GPC_HIZ_HOLD && s_q.hiz_cnt != 4'h0) |=> gate_hiz)
        else $error("gates not floating during hold");
    a_all_on_hiz: assert property (@(posedge clock) disable iff (!nrst)
        (all_gate_on && s_q.goa[9:8] == 2'b11) |=> gate_hiz)
        else $error("all gate on high impedance missing");
endmodule // gpc_top
`default_nettype wire

/* bench/gpc_host_model.sv */
// Host controller model writing serial commands to the block
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defines.svh"
module gpc_host_model (
    // Clock
    input wire logic clock,
    // Serial pins
    output logic csx_n,
    output logic scl,
    output logic sda,
    output logic dcx
);
    // Deselected, clock parked low
    initial begin
        csx_n = 1'b1;
        scl = 1'b0;
        sda = 1'b1;
        dcx = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Eight bits, MSB first, two cycles low and two high each
    task automatic send_byte(input logic dc, input logic [7:0] b);
        dcx = dc;
        for (int i = 7; i >= 0; i--) begin
            sda = b[i];
            scl = 1'b0;
            wait_cyc(2);
            scl = 1'b1;
            wait_cyc(2);
        end
    endtask

    task automatic send_cmd(input logic [7:0] cmd, input logic [23:0] par, input int n);
        wait_cyc(1);
        csx_n = 1'b0;
        send_byte(1'b0, cmd);
        for (int k = 0; k < n; k++) begin
            send_byte(1'b1, par[8*k +: 8]);
        end
        scl = 1'b0;
        wait_cyc(2);
        csx_n = 1'b1;
        sda = ~sda;
    endtask

    task automatic unlock();
        send_cmd(`GPC_CMD_UNLOCK, {16'h0000, `GPC_UNLOCK_KEY}, 1);
    endtask
endmodule // gpc_host_model
`default_nettype wire

/* bench/tb_gpc_top.sv */
// Self-checking testbench for the gate pump configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defines.svh"
module tb_gpc_top;
    logic clock, nrst, test_mode, sleep_in, all_gate_on, low_voltage_detect;
    logic two_frame_strategy, line_tick;
    wire logic csx_n, scl, sda, dcx;
    logic [3:0] vgh_ratio, vgl_ratio;
    logic [7:0] vgh_level_dv, vgl_level_dv;
    logic [15:0] supply_off;
    logic [2:0] pad_goa_sel, pad_vds_sel, pad_gch_sel;
    logic [1:0] gate_all_on_level, map_sel;
    logic vgh_clamp_en, vgl_clamp_en, supply_all_off, pad_force, gate_all_on;
    logic gate_hiz, extra_frames_go;
    int fails = 0;
    int compares = 0;
    int cycles = 0;

    gpc_host_model host_u (.clock(clock), .csx_n(csx_n), .scl(scl), .sda(sda), .dcx(dcx));
    gpc_top dut_u (.clock(clock), .nrst(nrst), .csx_n(csx_n), .scl(scl), .sda(sda),
        .dcx(dcx), .test_mode(test_mode), .sleep_in(sleep_in), .all_gate_on(all_gate_on),
        .low_voltage_detect(low_voltage_detect), .two_frame_strategy(two_frame_strategy),
        .line_tick(line_tick), .vgh_ratio(vgh_ratio), .vgh_clamp_en(vgh_clamp_en),
        .vgh_level_dv(vgh_level_dv), .vgl_ratio(vgl_ratio), .vgl_clamp_en(vgl_clamp_en),
        .vgl_level_dv(vgl_level_dv), .supply_off(supply_off),
        .supply_all_off(supply_all_off), .pad_force(pad_force), .pad_goa_sel(pad_goa_sel),
        .pad_vds_sel(pad_vds_sel), .pad_gch_sel(pad_gch_sel), .gate_all_on(gate_all_on),
        .gate_all_on_level(gate_all_on_level), .gate_hiz(gate_hiz),
        .extra_frames_go(extra_frames_go), .map_sel(map_sel));

    // ==========================================
    // Clock, timeout and shared tasks
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Bounded wait for the float hold or the extra-frame pulse
    task automatic wait_out(input bit go);
        for (int n = 0; n < 4 && (go ? extra_frames_go : gate_hiz) !== 1'b1; n++) begin
            step(1);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        test_mode = 1'b1;
        step(2);
        chk("vgh", 24'h00_000F, 24'({vgh_ratio, vgh_clamp_en}));
        chk("vgh_lvl", 24'h00_0087, 24'(vgh_level_dv));
        chk("vgl", 24'h00_055A, 24'({vgl_ratio, vgl_level_dv}));
        chk("vgl_clamp", 24'h00_0000, 24'(vgl_clamp_en));
        chk("pads", 24'h00_0089, 24'({pad_goa_sel, pad_vds_sel, pad_gch_sel}));
        chk("byp_rst", 24'h00_0000, 24'({supply_all_off, supply_off}));
        test_mode = 1'b0;
        host_u.send_cmd(`GPC_CMD_HGP, 24'h00_0000, 1);
        step(5);
        chk("locked", 24'h00_000F, 24'({vgh_ratio, vgh_clamp_en}));
        $display("test reset and lock done");
    endtask

    task automatic t_pumps();
        for (int c = 0; c < 8; c++) begin
            host_u.send_cmd(`GPC_CMD_HGP, {16'h0000, c[0], 1'b0, c[1:0], 4'h0}, 1);
            host_u.send_cmd(`GPC_CMD_HCL, {21'h00_0000, c[2:0]}, 1);
            host_u.send_cmd(`GPC_CMD_LGP, {16'h0000, c[0], c[1], 3'h0, c[2:0]}, 1);
            step(5);
            chk("vgh_ratio", 24'(5 + c[1:0]), 24'(vgh_ratio));
            chk("vgh_clamp", 24'(c[0]), 24'(vgh_clamp_en));
            chk("vgh_lvl", 24'(120 + 5 * c), 24'(vgh_level_dv));
            chk("vgl_ratio", 24'(5 + c[0]), 24'(vgl_ratio));
            chk("vgl_clamp", 24'(c[1]), 24'(vgl_clamp_en));
            chk("vgl_lvl", 24'(90 + 5 * c), 24'(vgl_level_dv));
        end
        $display("test pumps done");
    endtask

    task automatic t_bypass();
        test_mode = 1'b1;
        host_u.send_cmd(`GPC_CMD_BYP, 24'h00_0001, 3);
        step(5);
        chk("master", 24'h01_FFFF, 24'({supply_all_off, supply_off}));
        host_u.send_cmd(`GPC_CMD_BYP, 24'h81_81A2, 3);
        step(5);
        chk("bypass", 24'({1'h0, 2'h3, 8'h81, 1'h1, 5'h11}), 24'({supply_all_off, supply_off}));
        test_mode = 1'b0;
        step(2);
        chk("test_off", 24'h00_0000, 24'({supply_all_off, supply_off}));
        $display("test bypass done");
    endtask

    task automatic t_goa();
        sleep_in = 1'b1;
        all_gate_on = 1'b1;
        for (int l = 0; l < 4; l++) begin
            host_u.send_cmd(`GPC_CMD_GOA, {8'h13, 6'h2B, l[1:0], 8'h3D}, 3);
            step(5);
            chk("level", 24'(l), 24'(gate_all_on_level));
            chk("all_hiz", 24'({1'b1, l == 3}), 24'({gate_all_on, gate_hiz}));
        end
        chk("pads", 24'h00_03EB, 24'({pad_force, pad_goa_sel, pad_vds_sel, pad_gch_sel}));
        chk("map", 24'h00_0001, 24'(map_sel));
        sleep_in = 1'b0;
        all_gate_on = 1'b0;
        step(3);
        chk("released", 24'h00_0000, 24'({pad_force, gate_all_on, gate_hiz}));
        $display("test gate array done");
    endtask

    task automatic t_float();
        host_u.send_cmd(`GPC_CMD_GOA, 24'h13_AC3D, 3);
        step(5);
        low_voltage_detect = 1'b1;
        step(1);
        low_voltage_detect = 1'b0;
        wait_out(0);
        chk("hold", 24'h00_0002, 24'({gate_hiz, extra_frames_go}));
        for (int k = 0; k < 4; k++) begin
            low_voltage_detect = (k == 1);
            step(1);
            low_voltage_detect = 1'b0;
            line_tick = 1'b1;
            step(1);
            line_tick = 1'b0;
            if (k < 3) begin
                step(3);
                chk("hold", 24'h00_0002, 24'({gate_hiz, extra_frames_go}));
            end
        end
        wait_out(1);
        chk("go", 24'h00_0001, 24'({gate_hiz, extra_frames_go}));
        step(1);
        chk("go_once", 24'h00_0000, 24'(extra_frames_go));
        host_u.send_cmd(`GPC_CMD_GOA, 24'h00_AC3D, 3);
        step(5);
        low_voltage_detect = 1'b1;
        step(1);
        low_voltage_detect = 1'b0;
        wait_out(1);
        chk("direct", 24'h00_0001, 24'({gate_hiz, extra_frames_go}));
        host_u.send_cmd(`GPC_CMD_GOA, 24'h10_AC3D, 3);
        step(5);
        low_voltage_detect = 1'b1;
        step(1);
        low_voltage_detect = 1'b0;
        line_tick = 1'b1;
        step(1);
        line_tick = 1'b0;
        chk("zero_hold", 24'h00_0001, 24'({gate_hiz, extra_frames_go}));
        $display("test float done");
    endtask

    initial begin
        {nrst, test_mode, sleep_in, all_gate_on} = 4'h0;
        {low_voltage_detect, line_tick} = 2'h0;
        two_frame_strategy = 1'b1;
        repeat (6) @(posedge clock);
        #1;
        nrst = 1'b1;
        t_reset();
        host_u.unlock();
        t_pumps();
        t_bypass();
        t_goa();
        t_float();
        report_and_stop();
    end
endmodule // tb_gpc_top
`default_nettype wire
